// file: psg_pkg.sv
package psg_pkg;
  // apb byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STEP    = 8'h04;
  localparam logic [7:0]  OFS_PERIODS = 8'h08;
  localparam logic [7:0]  OFS_AMP     = 8'h0C;
  localparam logic [7:0]  OFS_OFFSET  = 8'h10;
  localparam logic [7:0]  OFS_STATUS  = 8'h14;
  localparam logic [7:0]  OFS_LAST    = 8'h18;
  // ctrl mode codes, bits [2:0]
  localparam logic [2:0]  MODE_SINE   = 3'h0;
  localparam logic [2:0]  MODE_SQUARE = 3'h1;
  localparam logic [2:0]  MODE_TRI    = 3'h2;
  localparam logic [2:0]  MODE_CNT    = 3'h3;
  localparam logic [2:0]  MODE_CONST  = 3'h4;
  localparam logic [2:0]  MODE_NOISE  = 3'h5;
  localparam int          STAT_RUN    = 0;
  localparam int          STAT_DONE   = 1;
  // reset values and norm limits
  localparam logic [31:0] RST_STEP    = 32'h4000_0000;
  localparam logic [30:0] RST_PERIODS = 31'h0000_0000;
  localparam logic [15:0] RST_AMP     = 16'h7FFF;
  localparam logic [31:0] RST_OFFSET  = 32'h0000_0000;
  localparam logic [30:0] LFSR_SEED   = 31'h0000_0001;
  localparam logic [15:0] NORM_MAX    = 16'h7FFF;
  localparam logic [15:0] NORM_MIN    = 16'h8001;
  // timing and fifo size
  localparam int          CLK_HZ      = 100_000_000;
  localparam int          UPDATE_HZ   = 19_200;
  localparam int          TICK_DIV    = CLK_HZ / UPDATE_HZ;
  localparam int          FIFO_DEPTH  = 4;
  localparam int          FIFO_WIDTH  = 32;

  typedef enum logic [5:0] {
    PSG_SINE   = 6'h01,
    PSG_SQUARE = 6'h02,
    PSG_TRI    = 6'h04,
    PSG_CNT    = 6'h08,
    PSG_CONST  = 6'h10,
    PSG_NOISE  = 6'h20
  } psg_wave_t;

  typedef struct packed {
    psg_wave_t   wave;
    logic [31:0] step;
    logic [30:0] period_count;
    logic [15:0] amp;
    logic [31:0] offset;
  } psg_cfg_t;
endpackage : psg_pkg

// file: psg_gen.sv
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - software selects sine, square, triangle, counter, constant or noise and samples follow that shape.
// - while the run gate is low, generation halts and each sample is the offset.
// - a low-to-high run gate restarts the waveform at the start of a period.
// - the configured period_count is emitted, and a count of zero runs forever.
// - the frequency step moves only sine, square and triangle.
// - the period count counts only periodic shapes and holds up to 2^31-1.
// - after the last period the sample is the offset.
// - counter mode steps by one per tick from minus amplitude to plus amplitude.
// - noise samples come from a maximal 31-bit pseudo-random sequence.
module psg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_clk_en,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  // full only at DEPTH entries; an empty fifo must accept
  assign o_in_ready  = (fill != (AW+1)'(DEPTH));
  assign o_out_valid = (fill != '0);
  assign push        = i_clk_en && i_in_valid && o_in_ready;
  assign pop         = i_clk_en && o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_ptr];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (int'(wr_ptr) == DEPTH - 1) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (int'(rd_ptr) == DEPTH - 1) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : psg_fifo

module psg_gen #(
  parameter int TICK_DIV = psg_pkg::TICK_DIV
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  input  wire logic        i_run_gate,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             o_smp_valid,
  input  wire logic        i_smp_ready,
  output logic [31:0]      o_smp_data
);
  psg_pkg::psg_cfg_t cfg;
  logic [2:0]        mode_code;
  logic [15:0]       tick_cnt;
  logic              tick_due;
  logic              gate_s1, gate_s2, gate_s3;
  logic              run;
  logic              gate_rise;
  logic              gate_fall;
  logic [31:0]       phase;
  logic [30:0]       periods_done;
  logic              done;
  logic signed [31:0] cnt_val;
  logic [30:0]       lfsr;
  logic [31:0]       last;
  logic              fifo_ready;
  logic              push;
  logic              periodic;
  logic [32:0]       next_phase;
  logic signed [15:0] norm;
  logic [14:0]       half;
  logic [29:0]       parab;
  logic [15:0]       tri_q;
  logic signed [31:0] scaled;
  logic [31:0]       next_result;

  // apb slave: zero wait states, read data latched in setup phase
  assign pready = 1'b1;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      mode_code <= psg_pkg::MODE_SINE;
      cfg.step  <= psg_pkg::RST_STEP;
      cfg.period_count <= psg_pkg::RST_PERIODS;
      cfg.amp    <= psg_pkg::RST_AMP;
      cfg.offset <= psg_pkg::RST_OFFSET;
    end else if (i_clk_en && psel && penable && pwrite) begin
      case (paddr)
        psg_pkg::OFS_CTRL:    mode_code <= pwdata[2:0];
        psg_pkg::OFS_STEP:    cfg.step <= pwdata;
        psg_pkg::OFS_PERIODS: cfg.period_count <= pwdata[30:0];
        psg_pkg::OFS_AMP:     cfg.amp <= pwdata[15:0];
        psg_pkg::OFS_OFFSET:  cfg.offset <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (i_clk_en && psel && !penable) begin
      pslverr <= 1'b0;
      case (paddr)
        psg_pkg::OFS_CTRL:    prdata <= {29'h0000_0000, mode_code};
        psg_pkg::OFS_STEP:    prdata <= cfg.step;
        psg_pkg::OFS_PERIODS: prdata <= {1'b0, cfg.period_count};
        psg_pkg::OFS_AMP:     prdata <= {16'h0000, cfg.amp};
        psg_pkg::OFS_OFFSET:  prdata <= cfg.offset;
        psg_pkg::OFS_STATUS:  prdata <= {30'h0000_0000, done, run};
        psg_pkg::OFS_LAST:    prdata <= last;
        default: begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // unknown codes fall back to sine so the shape is never undefined
  always_comb begin
    case (mode_code)
      psg_pkg::MODE_SQUARE: cfg.wave = psg_pkg::PSG_SQUARE;
      psg_pkg::MODE_TRI:    cfg.wave = psg_pkg::PSG_TRI;
      psg_pkg::MODE_CNT:    cfg.wave = psg_pkg::PSG_CNT;
      psg_pkg::MODE_CONST:  cfg.wave = psg_pkg::PSG_CONST;
      psg_pkg::MODE_NOISE:  cfg.wave = psg_pkg::PSG_NOISE;
      default:              cfg.wave = psg_pkg::PSG_SINE;
    endcase
  end

  // gate pin sync; s1 only feeds s2
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      gate_s1 <= 1'b0;
      gate_s2 <= 1'b0;
      gate_s3 <= 1'b0;
      run     <= 1'b0;
    end else if (i_clk_en) begin
      gate_s1 <= i_run_gate;
      gate_s2 <= gate_s1;
      gate_s3 <= gate_s2;
      if (gate_s2 == gate_s3) begin
        run <= gate_s2;
      end
    end
  end
  assign gate_rise = (gate_s2 == gate_s3) && gate_s2 && !run;
  assign gate_fall = (gate_s2 == gate_s3) && !gate_s2 && run;

  // update tick; a stalled fifo holds the tick pending
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tick_cnt <= 16'h0000;
      tick_due <= 1'b0;
    end else if (i_clk_en) begin
      if (int'(tick_cnt) == TICK_DIV - 1) begin
        tick_cnt <= 16'h0000;
        tick_due <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
        if (push) begin
          tick_due <= 1'b0;
        end
      end
    end
  end
  assign push = i_clk_en && tick_due && fifo_ready;

  assign periodic   = (cfg.wave == psg_pkg::PSG_SINE) || (cfg.wave == psg_pkg::PSG_SQUARE)
                   || (cfg.wave == psg_pkg::PSG_TRI);
  assign next_phase = {1'b0, phase} + {1'b0, cfg.step};

  // waveform state
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      phase        <= 32'h0000_0000;
      periods_done <= 31'h0000_0000;
      done         <= 1'b0;
      cnt_val      <= 32'h0000_0000;
      lfsr         <= psg_pkg::LFSR_SEED;
    end else if (i_clk_en) begin
      if (gate_rise || !run) begin
        phase        <= 32'h0000_0000;
        periods_done <= 31'h0000_0000;
        done         <= 1'b0;
        cnt_val      <= -32'(signed'(cfg.amp));
      end else if (push && !done) begin
        if (periodic) begin
          phase <= next_phase[31:0];
          if (next_phase[32]) begin
            periods_done <= periods_done + 31'h0000_0001;
            if (cfg.period_count != '0 && periods_done + 31'h0000_0001 == cfg.period_count) begin
              done <= 1'b1;
            end
          end
        end
        if (cnt_val >= 32'(signed'(cfg.amp))) begin
          cnt_val <= -32'(signed'(cfg.amp));
        end else begin
          cnt_val <= cnt_val + 32'sh0000_0001;
        end
        lfsr <= {lfsr[29:0], lfsr[30] ^ lfsr[27]};
      end
    end
  end

  // parabolic sine keeps the lut out at a few percent of error
  assign half  = phase[30:16];
  assign parab = 30'(half) * 30'(15'h7FFF - half);
  assign tri_q = phase[31] ? ~phase[30:15] : phase[30:15];

  always_comb begin
    case (cfg.wave)
      psg_pkg::PSG_SINE:   norm = phase[31] ? -signed'(parab[28:13]) : signed'(parab[28:13]);
      psg_pkg::PSG_SQUARE: norm = phase[31] ? psg_pkg::NORM_MIN : psg_pkg::NORM_MAX;
      psg_pkg::PSG_TRI:    norm = {~tri_q[15], tri_q[14:0]};
      psg_pkg::PSG_NOISE:  norm = lfsr[15:0];
      default:             norm = psg_pkg::NORM_MAX;
    endcase
    if (cfg.wave == psg_pkg::PSG_SINE && parab[28]) begin
      norm = phase[31] ? psg_pkg::NORM_MIN : psg_pkg::NORM_MAX;
    end
    scaled = (32'(norm) * 32'(signed'(cfg.amp))) >>> 15;
    if (!run || done) begin
      next_result = cfg.offset;
    end else if (cfg.wave == psg_pkg::PSG_CNT) begin
      next_result = cfg.offset + cnt_val;
    end else if (cfg.wave == psg_pkg::PSG_CONST) begin
      next_result = cfg.offset + 32'(signed'(cfg.amp));
    end else begin
      next_result = cfg.offset + scaled;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      last <= 32'h0000_0000;
    end else if (push) begin
      last <= next_result;
    end
  end

  psg_fifo #(.WIDTH(psg_pkg::FIFO_WIDTH), .DEPTH(psg_pkg::FIFO_DEPTH)) u_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_sys_rst  (i_sys_rst),
    .i_clk_en   (i_clk_en),
    .i_in_valid (tick_due),
    .o_in_ready (fifo_ready),
    .i_in_data  (next_result),
    .o_out_valid(o_smp_valid),
    .i_out_ready(i_smp_ready),
    .o_out_data (o_smp_data)
  );

  default clocking cb @(posedge i_ref_clk iff i_clk_en); endclocking
  default disable iff (i_sys_rst);

  a_wave_onehot: assert property ($onehot(cfg.wave)) else $error("wave not one-hot");
  a_gate_low_off: assert property (push && !run |-> next_result == cfg.offset)
    else $error("gate low sample not offset");
  a_gate_restart: assert property (gate_rise |=> phase == 32'h0000_0000 && !done)
    else $error("no restart on gate rise");
  a_done_needs_count: assert property (done |-> cfg.period_count != '0)
    else $error("done with endless count");
  a_step_ignored: assert property (!periodic && $stable(cfg.wave) && run && !gate_rise |=> $stable(phase))
    else $error("phase moved in aperiodic mode");
  a_period_bound: assert property (cfg.period_count != '0 && $stable(cfg.period_count) && !done
    |-> periods_done < cfg.period_count) else $error("periods overrun");
  a_done_offset: assert property (push && done |-> next_result == cfg.offset)
    else $error("done sample not offset");
  a_count_step: assert property (push && run && !done && !gate_rise
    && cnt_val < 32'(signed'(cfg.amp)) |=> cnt_val == $past(cnt_val) + 32'sh0000_0001)
    else $error("counter step wrong");
  a_lfsr_alive: assert property (lfsr != '0) else $error("lfsr stuck at zero");
  a_push_once: assert property (push |=> !push) else $error("two samples in one tick");

  c_gate_rise: cover property (gate_rise);
  c_run_done: cover property (done && push);
  c_fifo_stall: cover property (tick_due && !fifo_ready);
  c_noise_push: cover property (push && run && cfg.wave == psg_pkg::PSG_NOISE);
endmodule : psg_gen

// file: psg_sink.sv
`timescale 1ns/1ps
module psg_sink (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_stall,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_data,
  output logic             o_ready,
  output logic             o_take,
  output logic [31:0]      o_word
);
  // random gaps model a consumer that is sometimes slow
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) o_ready <= 1'b0;
    else o_ready <= !i_stall && ($urandom_range(3) != 0);
  end
  assign o_take = i_valid && o_ready;
  assign o_word = i_data;
endmodule : psg_sink

// file: tb.sv
`timescale 1ns/1ps
module tb;
  localparam int TD = 8;
  logic clk, rst, clk_en, gate, psel, penable, pwrite, pready, pslverr, err, stall;
  logic smp_valid, smp_ready, take;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, smp_data, word;
  logic signed [31:0] q[$];
  int errors, checks, off, amp, hp, hn, nz, lead, lo, hi;
  psg_gen #(.TICK_DIV(TD)) dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_run_gate(gate),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .o_smp_valid(smp_valid), .i_smp_ready(smp_ready), .o_smp_data(smp_data));
  psg_sink sink (.i_ref_clk(clk), .i_sys_rst(rst), .i_stall(stall), .i_valid(smp_valid), .i_data(smp_data),
    .o_ready(smp_ready), .o_take(take), .o_word(word));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (take === 1'b1 && clk_en === 1'b1) q.push_back(word);
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic cfg(input logic [2:0] m, input logic [31:0] s, input logic [31:0] p, input int a, input int o);
    apb(1'b1, psg_pkg::OFS_CTRL, {29'h0, m});
    apb(1'b1, psg_pkg::OFS_STEP, s);
    apb(1'b1, psg_pkg::OFS_PERIODS, p);
    apb(1'b1, psg_pkg::OFS_AMP, a);
    apb(1'b1, psg_pkg::OFS_OFFSET, o);
  endtask : cfg
  task automatic grab(input int n);
    q.delete();
    while (q.size() < n) @(posedge clk);
  endtask : grab
  // square run from a fresh gate rise, counts non-offset samples
  task automatic sq(input logic [31:0] p);
    gate <= 1'b0;
    cfg(psg_pkg::MODE_SQUARE, 32'h2000_0000, p, amp, off);
    grab(6);
    gate <= 1'b1;
    grab(48);
    nz = 0;
    lead = 0;
    foreach (q[i]) begin
      if (q[i] != off) begin
        nz++;
        chk("square level", q[i], (q[i] == off + hp) ? off + hp : off + hn);
      end
      else if (nz == 0) lead++;
    end
  endtask : sq
  initial begin
    void'($urandom(32'hfa0022bc));
    {rst, clk_en, gate, psel, penable, pwrite, stall} = 7'b1110000;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, psg_pkg::OFS_STEP, 0);
    chk("step reset", rd, psg_pkg::RST_STEP);
    apb(1'b0, psg_pkg::OFS_PERIODS, 0);
    chk("periods reset", rd, {1'b0, psg_pkg::RST_PERIODS});
    apb(1'b0, psg_pkg::OFS_AMP, 0);
    chk("amp reset", rd, {16'h0, psg_pkg::RST_AMP});
    apb(1'b0, 8'h1C, 0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    off = int'($urandom_range(2000)) - 1000;
    amp = int'($urandom_range(20, 5));
    cfg(psg_pkg::MODE_CONST, 32'h1000_0000, 0, amp, off);
    grab(6);
    chk("constant", q[5], off + amp);
    cfg(psg_pkg::MODE_CNT, $urandom, 0, amp, off);
    // stall long enough to fill the fifo; ticks then stall the counter
    stall <= 1'b1;
    repeat (100) @(posedge clk);
    chk("fifo held", {31'h0, smp_valid}, 32'h1);
    stall <= 1'b0;
    repeat (200) begin
      @(posedge clk);
      clk_en <= 1'($urandom_range(1));
    end
    clk_en <= 1'b1;
    grab(30);
    for (int i = 1; i < 30; i++) chk("counter", q[i], (q[i-1] == off + amp) ? off - amp : q[i-1] + 1);
    gate <= 1'b0;
    grab(8);
    chk("gate low", q[7], off);
    amp = int'($urandom_range(32767, 256));
    hp = (32767 * amp) >>> 15;
    hn = (-32767 * amp) >>> 15;
    sq(2);
    chk("two periods", nz, 16);
    chk("after periods", q[47], off);
    sq(2);
    chk("restart", nz, 16);
    apb(1'b0, psg_pkg::OFS_STATUS, 0);
    chk("done flag", {31'h0, rd[psg_pkg::STAT_DONE]}, 32'h1);
    sq(0);
    chk("endless", nz, 48 - lead);
    cfg(psg_pkg::MODE_NOISE, 0, 0, amp, off);
    grab(24);
    lo = q[8];
    hi = q[8];
    for (int i = 8; i < 24; i++) begin
      chk("noise range", {31'h0, q[i] >= off - amp && q[i] <= off + amp}, 32'h1);
      if (q[i] < lo) lo = q[i];
      if (q[i] > hi) hi = q[i];
    end
    chk("noise varies", {31'h0, hi > lo}, 32'h1);
    conclude();
  end
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule : tb
